// ==== core/kwu_cfg.svh ====
// register offsets, field positions, reset values and timing for the key wake unit
`ifndef KWU_CFG_SVH
`define KWU_CFG_SVH
`define KWU_OFS_KEY_WAKE_CONTROL   12'hFC4
`define KWU_OFS_SYSTEM_CONTROL_ONE 12'hFC8
`define KWU_OFS_PORT_PULLUP        12'hFCC
`define KWU_OFS_STATUS             12'hFD0
`define KWU_RST_KEY_WAKE_CONTROL   8'h00
`define KWU_RST_SYSTEM_CONTROL_ONE 8'h00
`define KWU_RST_PORT_PULLUP        8'h00
`define KWU_SC1_RELM_BIT           5
`define KWU_SC1_STOP_BIT           7
`define KWU_HOLD_TIME_NS           1000
`define KWU_CLK_PERIOD_NS          50
`define KWU_HOLD_CYCLES ((`KWU_HOLD_TIME_NS + `KWU_CLK_PERIOD_NS - 1) / `KWU_CLK_PERIOD_NS)
`endif

// ==== core/kwu_key_filter.sv ====
// one key input: enable, level select and minimum hold filter
`include "kwu_cfg.svh"
module kwu_key_filter #(
    parameter int HOLD_CYCLES = `KWU_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // key input and its control
    input  wire logic wake_key_input,
    input  wire logic wake_input_enable,
    input  wire logic release_level,
    // results
    output logic      at_level,
    output logic      held
);
    typedef struct packed {
        logic [7:0] count;
        logic       held;
    } kwu_kf_t;

    kwu_kf_t st;
    kwu_kf_t next_st;

    // RULE3: enable gates input
    // RULE4: level selects polarity
    assign at_level = wake_input_enable && (wake_key_input == release_level);
    // RULE3: held dies with enable
    // registered flag alone would count one cycle after disable or level change
    assign held     = st.held && at_level;

    always_comb begin
        next_st = st;
        // RULE10: hold time filter
        if (!at_level) begin
            next_st.count = 8'h00;
            next_st.held  = 1'b0;
        end else if (st.count < 8'(HOLD_CYCLES - 1)) begin
            next_st.count = st.count + 8'h01;
        end else begin
            next_st.held = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // RULE10 no early release
    property p_held_needs_hold;
        @(posedge core_clk) disable iff (!resetn)
        $rose(held) |-> $past(at_level, HOLD_CYCLES);
    endproperty
    a_held_needs_hold : assert property (p_held_needs_hold) // RULE10
        else $error("key release seen before the hold time");

    // RULE10 no late release
    property p_held_after_hold;
        @(posedge core_clk) disable iff (!resetn)
        (at_level && st.count == 8'(HOLD_CYCLES - 1)) |=> (held || !at_level);
    endproperty
    a_held_after_hold : assert property (p_held_after_hold) // RULE10
        else $error("key level held long enough but no release seen");
endmodule

// ==== core/kwu_key_wake_unit.sv ====
// key wake unit: apb registers, release request and stop control
//
// Chosen here: register access over APB.
`include "kwu_cfg.svh"
// Overview of operation
// RULE1: leave stop when stop pin or any enabled key shows release
// RULE2: after reset only the stop pin releases; key bits cleared
// RULE3: a key input counts only while its enable bit is one
// RULE4: level bit zero releases on low, one releases on high
// RULE5: the stop pin has no disable and always releases
// RULE6: software enables a key before choosing its level
// RULE7: key control register at 0xFC4, four enable/level pairs, reset zero
// RULE8: software sets level release mode then the stop bit
// RULE9: software must not combine edge release mode with key wakeup
// RULE10: key release needs the level held at least 1 us
// RULE11: the stop pin stays low while waiting for a key release
// RULE12: stop requested with a source already released is skipped
// RULE13: key pull-up connects only when its pull-up bit is one
// RULE14: release request is OR of stop pin and matching keys
module kwu_key_wake_unit
    import kwu_pkg::*;
#(
    parameter int NUM_KEYS = 4
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                resetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic [31:0]              prdata,
    // pins
    input  wire logic                stop_pin,
    input  wire logic [NUM_KEYS-1:0] wake_key_input,
    output logic [NUM_KEYS-1:0]      key_pullup_enable,
    // power control
    output logic                     stop_mode,
    output logic                     stop_skipped
);
    typedef struct packed {
        logic [7:0]  key_wake_control;
        logic [7:0]  system_control_one;
        logic [7:0]  port_pullup_control;
        kwu_state_t  state;
        logic        stop_mode;
        logic        skipped;
        logic [31:0] prdata;
    } kwu_regs_t;

    kwu_regs_t st;
    kwu_regs_t next_st;

    logic [NUM_KEYS-1:0] key_at_level;
    logic [NUM_KEYS-1:0] key_held;
    logic                level_now;
    logic                release_held;
    logic                acc;
    logic                mapped;

    for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key
        kwu_key_filter u_filter (
            .core_clk          (core_clk),
            .resetn            (resetn),
            .wake_key_input    (wake_key_input[k]),
            .wake_input_enable (st.key_wake_control[2*k]),
            .release_level     (st.key_wake_control[2*k+1]),
            .at_level          (key_at_level[k]),
            .held              (key_held[k])
        );
    end

    // RULE5: stop pin always counts
    // RULE14: single release request
    assign level_now    = stop_pin || (|key_at_level);
    assign release_held = stop_pin || (|key_held);

    assign acc     = psel && penable;
    assign mapped  = (paddr == `KWU_OFS_KEY_WAKE_CONTROL) ||
                     (paddr == `KWU_OFS_SYSTEM_CONTROL_ONE) ||
                     (paddr == `KWU_OFS_PORT_PULLUP) ||
                     (paddr == `KWU_OFS_STATUS);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = st.prdata;

    // RULE13: pull-up only when bit set
    assign key_pullup_enable = st.port_pullup_control[NUM_KEYS-1:0];
    assign stop_mode    = st.stop_mode;
    assign stop_skipped = st.skipped;

    always_comb begin
        next_st        = st;
        next_st.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `KWU_OFS_KEY_WAKE_CONTROL:   next_st.prdata = {24'h0, st.key_wake_control};
                `KWU_OFS_SYSTEM_CONTROL_ONE: next_st.prdata = {24'h0, st.system_control_one};
                `KWU_OFS_PORT_PULLUP:        next_st.prdata = {24'h0, st.port_pullup_control};
                `KWU_OFS_STATUS:             next_st.prdata = {30'h0, st.skipped, st.stop_mode};
                default:                     next_st.prdata = 32'h0000_0000;
            endcase
        end else if (acc && !pwrite) begin
            next_st.prdata = st.prdata;
        end
        // RULE7: register writes
        if (acc && pwrite) begin
            case (paddr)
                `KWU_OFS_KEY_WAKE_CONTROL:   next_st.key_wake_control    = pwdata[7:0];
                `KWU_OFS_SYSTEM_CONTROL_ONE: next_st.system_control_one  = pwdata[7:0];
                `KWU_OFS_PORT_PULLUP:        next_st.port_pullup_control = pwdata[7:0];
                default: ;
            endcase
        end
        case (st.state)
            KWU_RUN: begin
                if (st.system_control_one[`KWU_SC1_STOP_BIT]) begin
                    next_st.system_control_one[`KWU_SC1_STOP_BIT] = 1'b0;
                    // RULE12: already released, skip stop
                    if (level_now) begin
                        next_st.skipped = 1'b1;
                    end else begin
                        next_st.skipped   = 1'b0;
                        next_st.stop_mode = 1'b1;
                        next_st.state     = KWU_STOPPED;
                    end
                end
            end
            KWU_STOPPED: begin
                // RULE1: release ends stop
                if (release_held) begin
                    next_st.state = KWU_WAKE;
                end
            end
            KWU_WAKE: begin
                next_st.stop_mode = 1'b0;
                next_st.state     = KWU_RUN;
            end
            default: begin
                next_st.state     = KWU_RUN;
                next_st.stop_mode = 1'b0;
            end
        endcase
    end

    // RULE2: all control bits clear at reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st.key_wake_control    <= `KWU_RST_KEY_WAKE_CONTROL;
            st.system_control_one  <= `KWU_RST_SYSTEM_CONTROL_ONE;
            st.port_pullup_control <= `KWU_RST_PORT_PULLUP;
            st.state               <= KWU_RUN;
            st.stop_mode           <= 1'b0;
            st.skipped             <= 1'b0;
            st.prdata              <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    property p_skip_when_released;
        @(posedge core_clk) disable iff (!resetn)
        (st.state == KWU_RUN && st.system_control_one[`KWU_SC1_STOP_BIT] && level_now)
            |=> !stop_mode && stop_skipped;
    endproperty
    a_skip_when_released : assert property (p_skip_when_released) // RULE12
        else $error("stop entered although a source was at release level");

    property p_pin_wakes;
        @(posedge core_clk) disable iff (!resetn)
        (stop_mode && stop_pin) |-> ##[1:2] !stop_mode;
    endproperty
    a_pin_wakes : assert property (p_pin_wakes) // RULE5
        else $error("stop pin high did not end stop");

    property p_no_wake_without_release;
        @(posedge core_clk) disable iff (!resetn)
        (st.state == KWU_STOPPED && !release_held) |=> st.state == KWU_STOPPED;
    endproperty
    a_no_wake_without_release : assert property (p_no_wake_without_release) // RULE1
        else $error("stop left without a release source");

    property p_disabled_ignored;
        @(posedge core_clk) disable iff (!resetn)
        (st.key_wake_control == 8'h00) |-> (release_held == stop_pin);
    endproperty
    a_disabled_ignored : assert property (p_disabled_ignored) // RULE3
        else $error("disabled key input counted as release");

    property p_level_match;
        @(posedge core_clk) disable iff (!resetn)
        key_at_level[0] |-> wake_key_input[0] == st.key_wake_control[1]
                            && st.key_wake_control[0];
    endproperty
    a_level_match : assert property (p_level_match) // RULE4
        else $error("key level match wrong");

    property p_pullup;
        @(posedge core_clk) disable iff (!resetn)
        $rose(st.port_pullup_control[0]) |-> key_pullup_enable[0];
    endproperty
    a_pullup : assert property (p_pullup) // RULE13
        else $error("pull-up not following its bit");

    property p_write_ctrl;
        @(posedge core_clk) disable iff (!resetn)
        (acc && pwrite && paddr == `KWU_OFS_KEY_WAKE_CONTROL)
            |=> st.key_wake_control == $past(pwdata[7:0]);
    endproperty
    a_write_ctrl : assert property (p_write_ctrl) // RULE7
        else $error("key control write lost");

    property p_request_or;
        @(posedge core_clk) disable iff (!resetn)
        (st.state == KWU_STOPPED && (|key_held)) |=> st.state == KWU_WAKE;
    endproperty
    a_request_or : assert property (p_request_or) // RULE14
        else $error("release request is not the or of sources");
endmodule

// ==== core/kwu_pkg.sv ====
// types of the key wake unit
package kwu_pkg;
    typedef enum logic [2:0] {
        KWU_RUN     = 3'b001,
        KWU_STOPPED = 3'b010,
        KWU_WAKE    = 3'b100
    } kwu_state_t;
endpackage

// ==== test/kwu_keys_model.sv ====
// partner model: external key switches and the stop release source
module kwu_keys_model (
    // clock
    input  wire logic       core_clk,
    // levels commanded by the bench
    input  wire logic [3:0] drive_on,
    input  wire logic [3:0] drive_val,
    input  wire logic       stop_level,
    // pins
    input  wire logic [3:0] key_pullup_enable,
    output logic [3:0]      wake_key_input,
    output logic            stop_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wobble = 4'h5;
    // a floating key must not look like a steady level
    always @(posedge core_clk) begin
        wobble <= ~wobble;
    end
    // levels held as long as commanded
    always_comb begin
        stop_pin = stop_level;
        for (int k = 0; k < 4; k++) begin
            wake_key_input[k] = drive_on[k] ? drive_val[k] : wobble[k];
            // released key reads steady high only when pulled up
            if (!drive_on[k] && key_pullup_enable[k]) wake_key_input[k] = 1'b1;
        end
    end
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the key wake unit
`include "kwu_cfg.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0;
    logic        resetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        stop_pin;
    logic        stop_mode;
    logic        stop_skipped;
    logic        stop_level = 0;
    logic [3:0]  wake_key_input;
    logic [3:0]  key_pullup_enable;
    logic [3:0]  drive_on = 0;
    logic [3:0]  drive_val = 0;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cycles = 0;

    kwu_key_wake_unit #(.NUM_KEYS(4)) uut (
        .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .stop_pin(stop_pin),
        .wake_key_input(wake_key_input), .key_pullup_enable(key_pullup_enable),
        .stop_mode(stop_mode), .stop_skipped(stop_skipped));
    kwu_keys_model keys (
        .core_clk(core_clk), .drive_on(drive_on), .drive_val(drive_val),
        .stop_level(stop_level), .key_pullup_enable(key_pullup_enable),
        .wake_key_input(wake_key_input), .stop_pin(stop_pin));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // hang guard, far above the roughly 500 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] ex, input string nm);
        bus(0, a, 0);
        `CHK(nm, ex, rd)
    endtask

    task automatic enter_stop();
        bus(1, `KWU_OFS_SYSTEM_CONTROL_ONE, 32'h000000A0);
        repeat (3) @(negedge core_clk);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1;
        rdchk(`KWU_OFS_KEY_WAKE_CONTROL, 0, "kwc_rst");
        rdchk(`KWU_OFS_PORT_PULLUP, 0, "pullup_rst");
        rdchk(`KWU_OFS_STATUS, 0, "status_rst");
        rdchk(12'hFE0, 0, "unmapped_rd");
        `CHK("unmapped_err", 1'b1, err)
        bus(1, `KWU_OFS_KEY_WAKE_CONTROL, 32'h00000055);
        bus(1, `KWU_OFS_KEY_WAKE_CONTROL, 32'h000000FF);
        rdchk(`KWU_OFS_KEY_WAKE_CONTROL, 32'hFF, "kwc_rw");
        bus(1, `KWU_OFS_PORT_PULLUP, 32'h00000005);
        repeat (2) @(negedge core_clk);
        `CHK("pullup", 4'h5, key_pullup_enable)
        `CHK("key_pulled", 1'b1, wake_key_input[0])
        bus(1, `KWU_OFS_KEY_WAKE_CONTROL, 0);
        drive_on <= 4'hF;
        enter_stop();
        `CHK("stop_entered", 1'b1, stop_mode)
        rdchk(`KWU_OFS_STATUS, 32'h1, "status_stop");
        @(posedge core_clk);
        stop_level <= 1;
        repeat (3) @(negedge core_clk);
        `CHK("pin_wake", 1'b0, stop_mode)
        rdchk(`KWU_OFS_SYSTEM_CONTROL_ONE, 32'h20, "sc1_stop_clr");
        enter_stop();
        `CHK("pin_skip", 1'b1, stop_skipped)
        rdchk(`KWU_OFS_STATUS, 32'h2, "status_skip");
        @(posedge core_clk);
        stop_level <= 0;
        // every key at both levels: a short pulse is ignored, a held level wakes
        for (int k = 0; k < 4; k++) begin
            for (int l = 0; l < 2; l++) begin
                @(posedge core_clk);
                drive_val <= {4{~l[0]}};
                bus(1, `KWU_OFS_KEY_WAKE_CONTROL, 32'(1) << (2 * k));
                bus(1, `KWU_OFS_KEY_WAKE_CONTROL, 32'(1 + 2 * l) << (2 * k));
                enter_stop();
                `CHK("key_stop", 1'b1, stop_mode)
                @(posedge core_clk);
                drive_val[k] <= l[0];
                repeat (10) @(posedge core_clk);
                drive_val[k] <= ~l[0];
                repeat (2) @(negedge core_clk);
                `CHK("short_pulse", 1'b1, stop_mode)
                @(posedge core_clk);
                drive_val[k] <= l[0];
                repeat (`KWU_HOLD_CYCLES + 6) @(negedge core_clk);
                `CHK("key_wake", 1'b0, stop_mode)
            end
        end
        enter_stop();
        `CHK("key_skip", 1'b1, stop_skipped)
        end_of_test();
    end
endmodule
